// ===== hdl/ccu_capture_compare_units.sv
`timescale 1ns/1ps
module ccu_capture_compare_units import ccu_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Shared time bases and their select bits
  input wire logic [15:0] timer_a_count,
  input wire logic [15:0] timer_b_count,
  input wire logic [1:0] timer_select,
  // Device configuration for unit two routing
  input wire logic alt_pin_select_cfg,
  input wire logic micro_mode,
  input wire logic pins80_device,
  // Software register writes and flag clears
  input wire ccu_sw_write_t sw_write,
  input wire logic [CCU_UNITS-1:0] flag_clear,
  input wire logic [CCU_UNITS-1:0] unit_event_irq_enable,
  // Pin levels as seen on the pads
  input wire logic unit1_pin_in,
  input wire logic portc_bit1_pin_in,
  input wire logic porte_bit7_pin_in,
  input wire logic portb_bit3_pin_in,
  input wire logic unit3_pin_in,
  // A/D converter status
  input wire logic adc_enabled,
  // Register readback
  output logic [CCU_UNITS-1:0][3:0] unit_control,
  output logic [CCU_UNITS-1:0][15:0] unit_data_pair,
  // Event flags and interrupt requests
  output logic [CCU_UNITS-1:0] unit_event_flag,
  output logic [CCU_UNITS-1:0] unit_event_irq,
  // Compare output latches and ownership of the pin
  output logic [CCU_UNITS-1:0] unit_pin_out,
  output logic [CCU_UNITS-1:0] unit_pin_own,
  output logic portc_bit1_pin_own,
  output logic porte_bit7_pin_own,
  output logic portb_bit3_pin_own,
  // Special event triggers
  output logic timer_a_reset,
  output logic timer_b_reset,
  output logic adc_start
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  ccu_state_t st; // Registered state
  ccu_state_t next_st; // Next state
  logic unit2_level; // Routed level of unit two pin
  logic use_porte; // Alternate location is porte_bit7
  logic [CCU_UNITS-1:0] pin_level; // Pad levels per unit
  logic [CCU_UNITS-1:0][15:0] tbase; // Selected time base per unit
  logic [CCU_UNITS-1:0] cap_v; // Capture event this cycle
  logic [CCU_UNITS-1:0] match_v; // Compare match this cycle
  logic [CCU_UNITS-1:0] rise_v; // Rising edge this cycle
  logic [CCU_UNITS-1:0] ctrl_wr_v; // Control write to unit this cycle

  // ---------------------------------------------------------------
  // Pin routing
  // ---------------------------------------------------------------
  // Microcontroller mode and small packages only have porte_bit7
  assign use_porte = micro_mode | ~pins80_device;
  always_comb begin
    if (alt_pin_select_cfg) begin
      unit2_level = portc_bit1_pin_in;
    end else if (use_porte) begin
      unit2_level = porte_bit7_pin_in;
    end else begin
      unit2_level = portb_bit3_pin_in;
    end
  end
  // Pad level, not the output latch, feeds edge detection
  assign pin_level = {unit3_pin_in, unit2_level, unit1_pin_in};

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  // Order inside a unit: hardware events first, then software,
  // then capture data so a capture beats a byte write
  always_comb begin
    logic [3:0] m;
    logic lvl;
    logic fall;
    logic is_cap;
    logic is_cmp;
    logic eq;
    logic sel_b;
    logic [3:0] nm;
    m = CCU_MODE_RST;
    lvl = 1'b0;
    fall = 1'b0;
    is_cap = 1'b0;
    is_cmp = 1'b0;
    eq = 1'b0;
    sel_b = 1'b0;
    nm = CCU_MODE_RST;
    next_st = st;
    next_st.timer_a_reset = 1'b0;
    next_st.timer_b_reset = 1'b0;
    next_st.adc_start = 1'b0;
    for (int i = 0; i < CCU_UNITS; i++) begin
      m = st.unit[i].mode;
      lvl = pin_level[i];
      sel_b = ccu_uses_timer_b(timer_select, 2'(i));
      // Capture and compare never look at the PWM time base
      tbase[i] = sel_b ? timer_b_count : timer_a_count;
      rise_v[i] = ~st.unit[i].pin_prev & lvl;
      fall = st.unit[i].pin_prev & ~lvl;
      next_st.unit[i].pin_prev = lvl;
      is_cap = (m[3:2] == CCU_CAP_CLASS);
      is_cmp = (m == CCU_MODE_CMP_TOGGLE) || (m == CCU_MODE_CMP_SET) || (m == CCU_MODE_CMP_CLR) ||
               (m == CCU_MODE_CMP_SWINT) || (m == CCU_MODE_CMP_SPECIAL);
      // Capture prescaler counts rising edges only while capturing
      if (is_cap) begin
        if (rise_v[i]) begin
          next_st.unit[i].presc = st.unit[i].presc + 4'h1;
        end
      end else begin
        next_st.unit[i].presc = CCU_PRESC_RST;
      end
      // Event select; a prescaler switch keeps the running count
      unique case (m)
        CCU_MODE_CAP_FALL: cap_v[i] = fall;
        CCU_MODE_CAP_RISE: cap_v[i] = rise_v[i];
        CCU_MODE_CAP_RISE4: cap_v[i] = rise_v[i] & (st.unit[i].presc[1:0] == CCU_PRESC4_LAST);
        CCU_MODE_CAP_RISE16: cap_v[i] = rise_v[i] & (st.unit[i].presc == CCU_PRESC16_LAST);
        default: cap_v[i] = 1'b0;
      endcase
      // Match fires once as the timer arrives at the register value
      eq = (tbase[i] == st.unit[i].data);
      next_st.unit[i].eq_prev = eq;
      match_v[i] = is_cmp & eq & ~st.unit[i].eq_prev;
      if (match_v[i]) begin
        unique case (m)
          CCU_MODE_CMP_TOGGLE: next_st.unit[i].out_latch = ~st.unit[i].out_latch;
          CCU_MODE_CMP_SET: next_st.unit[i].out_latch = 1'b1;
          CCU_MODE_CMP_CLR: next_st.unit[i].out_latch = 1'b0;
          CCU_MODE_CMP_SPECIAL: begin
            // Unit three has no trigger and behaves as interrupt mode
            if (i < 2) begin
              next_st.timer_a_reset = next_st.timer_a_reset | ~sel_b;
              next_st.timer_b_reset = next_st.timer_b_reset | sel_b;
            end
            if (i == 1) begin
              next_st.adc_start = adc_enabled;
            end
          end
          default: begin
            // Software interrupt mode leaves the latch alone
            next_st.unit[i].out_latch = st.unit[i].out_latch;
          end
        endcase
      end
      // Sticky flag: a new event wins over a clear in the same cycle
      if (cap_v[i] | match_v[i]) begin
        next_st.unit[i].flag = 1'b1;
      end else if (flag_clear[i]) begin
        next_st.unit[i].flag = 1'b0;
      end
      // Software writes to the unit registers
      ctrl_wr_v[i] = sw_write.wr && (sw_write.unit == 2'(i)) && (sw_write.sel == CCU_SEL_CTRL);
      if (ctrl_wr_v[i]) begin
        nm = sw_write.data[3:0];
        next_st.unit[i].mode = nm;
        if (nm == CCU_MODE_OFF) begin
          // Disable resets the unit but not the port data latch
          next_st.unit[i].out_latch = 1'b0;
          next_st.unit[i].presc = CCU_PRESC_RST;
        end else if (nm == CCU_MODE_CMP_SET) begin
          next_st.unit[i].out_latch = 1'b0;
        end else if (nm == CCU_MODE_CMP_CLR) begin
          next_st.unit[i].out_latch = 1'b1;
        end
      end
      if (sw_write.wr && (sw_write.unit == 2'(i)) && (sw_write.sel == CCU_SEL_LOW)) begin
        next_st.unit[i].data[7:0] = sw_write.data;
      end
      if (sw_write.wr && (sw_write.unit == 2'(i)) && (sw_write.sel == CCU_SEL_HIGH)) begin
        next_st.unit[i].data[15:8] = sw_write.data;
      end
      // Unprotected overwrite of whatever was captured before
      if (cap_v[i]) begin
        next_st.unit[i].data = tbase[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Ownership decodes registered mode; interrupt mode hands back
  // the pin to the port latch
  always_comb begin
    for (int i = 0; i < CCU_UNITS; i++) begin
      unit_control[i] = st.unit[i].mode;
      unit_data_pair[i] = st.unit[i].data;
      unit_event_flag[i] = st.unit[i].flag;
      unit_event_irq[i] = st.unit[i].flag & unit_event_irq_enable[i];
      unit_pin_out[i] = st.unit[i].out_latch;
      unit_pin_own[i] = (st.unit[i].mode == CCU_MODE_CMP_TOGGLE) || (st.unit[i].mode == CCU_MODE_CMP_SET) ||
                        (st.unit[i].mode == CCU_MODE_CMP_CLR);
    end
  end
  assign portc_bit1_pin_own = unit_pin_own[1] & alt_pin_select_cfg;
  assign porte_bit7_pin_own = unit_pin_own[1] & ~alt_pin_select_cfg & use_porte;
  assign portb_bit3_pin_own = unit_pin_own[1] & ~alt_pin_select_cfg & ~use_porte;
  assign timer_a_reset = st.timer_a_reset;
  assign timer_b_reset = st.timer_b_reset;
  assign adc_start = st.adc_start;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  route_primary_a: assert property (alt_pin_select_cfg |-> unit2_level == portc_bit1_pin_in)
    else $error("unit two pin not on primary location");
  route_alternate_a: assert property (!alt_pin_select_cfg && micro_mode |-> unit2_level == porte_bit7_pin_in)
    else $error("unit two alternate pin wrong");
  // Small packages have only one alternate place for unit two
  route_small_pkg_a: assert property (!alt_pin_select_cfg && !pins80_device |->
                                      unit2_level == porte_bit7_pin_in)
    else $error("unit two pin not on porte_bit7 for small package");
  route_portb_a: assert property (!alt_pin_select_cfg && !micro_mode && pins80_device |->
                                  unit2_level == portb_bit3_pin_in)
    else $error("unit two pin not on portb_bit3");
  tsel_unit1_a: assert property (timer_select != 2'h3 |-> tbase[0] == timer_a_count)
    else $error("unit one time base wrong");
  tsel_unit3_a: assert property (timer_select[0] ^ timer_select[1] |-> tbase[2] == timer_b_count)
    else $error("unit three time base wrong");
  // Unit two follows the low select bit in every mapping
  tsel_unit2_a: assert property (tbase[1] == (timer_select[0] ? timer_b_count : timer_a_count))
    else $error("unit two time base wrong");
  tsel_all_b_a: assert property (timer_select == 2'h3 |-> tbase[0] == timer_b_count)
    else $error("unit one not on timer_b in all-b mapping");
  adc_source_a: assert property (adc_start |-> $past(match_v[1]) && $past(st.unit[1].mode) == CCU_MODE_CMP_SPECIAL)
    else $error("conversion start without unit two trigger");
  special_src_a: assert property (timer_a_reset || timer_b_reset |-> $past(match_v[0]) || $past(match_v[1]))
    else $error("timer reset without unit one or two match");
  // Special event pulses land one cycle after the match, on the unit's own timer
  adc_trigger_a: assert property (match_v[1] && st.unit[1].mode == CCU_MODE_CMP_SPECIAL |=>
                                  adc_start == $past(adc_enabled))
    else $error("unit two special event missed conversion start");
  unit1_reset_a: assert property (match_v[0] && st.unit[0].mode == CCU_MODE_CMP_SPECIAL |=>
                                  (($past(timer_select) == 2'h3) ? timer_b_reset : timer_a_reset))
    else $error("unit one special event missed timer reset");
  unit2_reset_a: assert property (match_v[1] && st.unit[1].mode == CCU_MODE_CMP_SPECIAL |=>
                                  ($past(timer_select[0]) ? timer_b_reset : timer_a_reset))
    else $error("unit two special event missed timer reset");
  unit3_no_trigger_a: assert property (match_v[2] && !match_v[0] && !match_v[1] |=>
                                       !timer_a_reset && !timer_b_reset)
    else $error("unit three raised a timer reset");

  for (genvar g = 0; g < CCU_UNITS; g++) begin : g_chk
    sequence s_capture;
      cap_v[g] && !ctrl_wr_v[g];
    endsequence
    sequence s_toggle_match;
      match_v[g] && st.unit[g].mode == CCU_MODE_CMP_TOGGLE && !ctrl_wr_v[g];
    endsequence
    capture_load_a: assert property (s_capture |=> st.unit[g].data == $past(tbase[g]))
      else $error("captured value differs from time base");
    capture_flag_a: assert property (cap_v[g] |=> st.unit[g].flag)
      else $error("capture did not set flag");
    flag_sticky_a: assert property (st.unit[g].flag && !flag_clear[g] |=> st.unit[g].flag)
      else $error("flag dropped without a clear");
    presc_clear_a: assert property (st.unit[g].mode[3:2] != CCU_CAP_CLASS |=> st.unit[g].presc == 4'h0)
      else $error("prescaler not cleared outside capture");
    every_fourth_a: assert property (st.unit[g].mode == CCU_MODE_CAP_RISE4 && rise_v[g] |->
                                     cap_v[g] == (st.unit[g].presc[1:0] == 2'h3))
      else $error("fourth edge capture wrong");
    toggle_pin_a: assert property (s_toggle_match |=> st.unit[g].out_latch != $past(st.unit[g].out_latch))
      else $error("toggle match did not toggle");
    ctrl_clear_a: assert property (ctrl_wr_v[g] && sw_write.data[3:0] == 4'h0 |=>
                                   !st.unit[g].out_latch && st.unit[g].mode == 4'h0 ##1 st.unit[g].presc == 4'h0)
      else $error("clearing control left latch set");
    swint_pin_a: assert property (match_v[g] && st.unit[g].mode == CCU_MODE_CMP_SWINT && !ctrl_wr_v[g] |=>
                                  $stable(st.unit[g].out_latch) && st.unit[g].flag)
      else $error("interrupt mode touched pin or missed flag");
    // Fixed pin actions; a same-cycle control write of code 0000, 1000 or 1001 wins
    set_pin_a: assert property (match_v[g] && st.unit[g].mode == CCU_MODE_CMP_SET && !ctrl_wr_v[g] |=>
                                st.unit[g].out_latch)
      else $error("set-on-match left pin low");
    clear_pin_a: assert property (match_v[g] && st.unit[g].mode == CCU_MODE_CMP_CLR && !ctrl_wr_v[g] |=>
                                  !st.unit[g].out_latch)
      else $error("clear-on-match left pin high");
    every_sixteenth_a: assert property (st.unit[g].mode == CCU_MODE_CAP_RISE16 && rise_v[g] |->
                                        cap_v[g] == (st.unit[g].presc == CCU_PRESC16_LAST))
      else $error("sixteenth edge capture wrong");
    fall_capture_a: assert property (st.unit[g].mode == CCU_MODE_CAP_FALL |->
                                     cap_v[g] == (st.unit[g].pin_prev && !pin_level[g]))
      else $error("falling edge capture wrong");
    flag_clear_a: assert property (flag_clear[g] && !cap_v[g] && !match_v[g] |=> !st.unit[g].flag)
      else $error("flag clear ignored");
    disabled_quiet_a: assert property (st.unit[g].mode == CCU_MODE_OFF |-> !cap_v[g] && !match_v[g])
      else $error("disabled unit raised an event");
  end

endmodule // ccu_capture_compare_units

// ===== inc/ccu_pkg.sv
// Overview of operation
// - Capture and compare use timer_a or timer_b
// - Timer select picks one of four mappings
// - Unit two uses portc_bit1_pin when selected
// - Alternate pin: porte_bit7 or portb_bit3 by mode and package
// - Capture copies selected timer into data pair
// - Capture on fall, rise, 4th, 16th rise
// - Capture sets sticky flag, software clears it
// - Newer capture overwrites unread value
// - Edge detect uses real pin level always
// - Prescaler cleared when off or not capturing
// - Prescaler switch keeps count, may flag
// - Compare match sets flag and acts on pin
// - Match drives high, low, toggles or nothing
// - Clearing control forces output latch low
// - Software interrupt mode only sets flag
// - Special event resets units one/two timer
// - Unit two special event starts conversion
// - Unit three special event equals interrupt mode
// - Capture mode codes 0100 to 0111
// - Compare codes 0010, 1000 to 1011
// - Code 0000 disables and resets unit
// - Data bytes and control are read/write
package ccu_pkg;

  // ---------------------------------------------------------------
  // Sizes and reset values
  // ---------------------------------------------------------------
  localparam int CCU_UNITS = 3;
  localparam logic [1:0] CCU_TSEL_RST = 2'h0;
  localparam logic [3:0] CCU_MODE_RST = 4'h0;
  localparam logic [15:0] CCU_DATA_RST = 16'h0000;
  localparam logic [3:0] CCU_PRESC_RST = 4'h0;

  // ---------------------------------------------------------------
  // Mode field codes
  // ---------------------------------------------------------------
  localparam logic [3:0] CCU_MODE_OFF = 4'h0;
  localparam logic [3:0] CCU_MODE_CMP_TOGGLE = 4'h2;
  localparam logic [3:0] CCU_MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] CCU_MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] CCU_MODE_CAP_RISE4 = 4'h6;
  localparam logic [3:0] CCU_MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0] CCU_MODE_CMP_SET = 4'h8;
  localparam logic [3:0] CCU_MODE_CMP_CLR = 4'h9;
  localparam logic [3:0] CCU_MODE_CMP_SWINT = 4'ha;
  localparam logic [3:0] CCU_MODE_CMP_SPECIAL = 4'hb;
  localparam logic [1:0] CCU_CAP_CLASS = 2'h1;

  // ---------------------------------------------------------------
  // Prescaler terminal counts
  // ---------------------------------------------------------------
  localparam logic [1:0] CCU_PRESC4_LAST = 2'h3;
  localparam logic [3:0] CCU_PRESC16_LAST = 4'hf;

  // ---------------------------------------------------------------
  // Software write port selectors
  // ---------------------------------------------------------------
  localparam logic [1:0] CCU_SEL_CTRL = 2'h0;
  localparam logic [1:0] CCU_SEL_LOW = 2'h1;
  localparam logic [1:0] CCU_SEL_HIGH = 2'h2;

  // Software write to one unit register
  typedef struct packed {
    logic wr;
    logic [1:0] unit;
    logic [1:0] sel;
    logic [7:0] data;
  } ccu_sw_write_t;

  // State of one unit
  typedef struct packed {
    logic [3:0] mode;
    logic [15:0] data;
    logic flag;
    logic out_latch;
    logic pin_prev;
    logic eq_prev;
    logic [3:0] presc;
  } ccu_unit_t;

  // Whole block state
  typedef struct packed {
    ccu_unit_t [CCU_UNITS-1:0] unit;
    logic timer_a_reset;
    logic timer_b_reset;
    logic adc_start;
  } ccu_state_t;

  // True when unit idx takes its time base from timer_b
  function automatic logic ccu_uses_timer_b(input logic [1:0] sel, input logic [1:0] idx);
    logic r;
    r = 1'b0;
    case (sel)
      2'h0: r = 1'b0;
      2'h1: r = (idx != 2'h0);
      2'h2: r = (idx == 2'h2);
      2'h3: r = 1'b1;
    endcase
    return r;
  endfunction

endpackage

// ===== tb/ccu_pin_source.sv
`timescale 1ns/1ps
// Far-side signal source that drives the unit pads
module ccu_pin_source (
  // Clock
  input wire logic sys_clk,
  // Requested unit levels and unit two route (0 portc, 1 porte, 2 portb)
  input wire logic [2:0] lvl,
  input wire logic [1:0] route,
  // Pads
  output logic unit1_pin_in = 1'b0,
  output logic portc_bit1_pin_in = 1'b0,
  output logic porte_bit7_pin_in = 1'b0,
  output logic portb_bit3_pin_in = 1'b0,
  output logic unit3_pin_in = 1'b0
);
  logic wiggle = 1'b0; // Pattern on pads not carrying unit two
  // Unused pads toggle every cycle, so a wrong pin mux shows as false captures
  always_ff @(posedge sys_clk) begin
    wiggle <= ~wiggle;
    unit1_pin_in <= lvl[0];
    unit3_pin_in <= lvl[2];
    portc_bit1_pin_in <= (route == 2'h0) ? lvl[1] : wiggle;
    porte_bit7_pin_in <= (route == 2'h1) ? lvl[1] : ~wiggle;
    portb_bit3_pin_in <= (route == 2'h2) ? lvl[1] : wiggle;
  end
endmodule // ccu_pin_source

// ===== tb/test_capture_compare_units.sv
`timescale 1ns/1ps
module test_capture_compare_units import ccu_pkg::*; ;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic sys_clk = 1'b0, rst_b, alt_pin_select_cfg, micro_mode, pins80_device, adc_enabled;
  logic [15:0] timer_a_count, timer_b_count;
  logic [1:0] timer_select, route;
  ccu_sw_write_t sw_write;
  logic [2:0] flag_clear, unit_event_irq_enable, lvl, unit_event_flag, unit_event_irq, unit_pin_out, unit_pin_own;
  logic unit1_pin_in, portc_bit1_pin_in, porte_bit7_pin_in, portb_bit3_pin_in, unit3_pin_in;
  logic [2:0][3:0] unit_control;
  logic [2:0][15:0] unit_data_pair;
  logic portc_bit1_pin_own, porte_bit7_pin_own, portb_bit3_pin_own, timer_a_reset, timer_b_reset, adc_start;
  int failures = 0, n_checks = 0, u, m, j, k, n;
  logic [15:0] d;
  logic act, lat, b, sp, o;
  logic [3:0] cmodes [5] = '{4'h9, 4'h8, 4'h2, 4'ha, 4'hb};

  initial forever #12.5 sys_clk = ~sys_clk;

  ccu_capture_compare_units u_dut (.sys_clk, .rst_b, .timer_a_count, .timer_b_count, .timer_select,
    .alt_pin_select_cfg, .micro_mode, .pins80_device, .sw_write, .flag_clear, .unit_event_irq_enable,
    .unit1_pin_in, .portc_bit1_pin_in, .porte_bit7_pin_in, .portb_bit3_pin_in, .unit3_pin_in, .adc_enabled,
    .unit_control, .unit_data_pair, .unit_event_flag, .unit_event_irq, .unit_pin_out, .unit_pin_own,
    .portc_bit1_pin_own, .porte_bit7_pin_own, .portb_bit3_pin_own, .timer_a_reset, .timer_b_reset, .adc_start);
  ccu_pin_source u_src (.sys_clk, .lvl, .route, .unit1_pin_in, .portc_bit1_pin_in, .porte_bit7_pin_in,
    .portb_bit3_pin_in, .unit3_pin_in);

  // ---------------------------------------------------------------
  // Helpers; values are read just after an edge, before its updates land
  // ---------------------------------------------------------------
  function automatic logic use_b(input logic [1:0] s, input int i);
    return (s == 2'h3) || (s == 2'h1 && i > 0) || (s == 2'h2 && i == 2);
  endfunction
  task automatic tick(input int c);
    repeat (c) @(posedge sys_clk);
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e, input string msg);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: %s unit %0d mode %h got %h want %h", $time, msg, u, m, g, e);
    end
  endtask
  task automatic wr(input logic [1:0] s, input logic [7:0] v);
    sw_write <= '{wr: 1'b1, unit: 2'(u), sel: s, data: v};
    tick(1);
    sw_write.wr <= 1'b0;
    tick(1);
  endtask
  task automatic clr();
    flag_clear[u] <= 1'b1;
    tick(1);
    flag_clear[u] <= 1'b0;
    tick(1);
  endtask
  // New random configuration; route mirrors the expected unit two pad
  task automatic shuffle();
    logic c, mc, p;
    c = 1'($urandom);
    mc = 1'($urandom);
    p = 1'($urandom);
    alt_pin_select_cfg <= c;
    micro_mode <= mc;
    pins80_device <= p;
    route <= c ? 2'h0 : ((mc || !p) ? 2'h1 : 2'h2);
    timer_select <= 2'($urandom);
    adc_enabled <= 1'($urandom);
    unit_event_irq_enable <= 3'($urandom);
    tick(1);
  endtask
  task automatic stop_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge sys_clk);
    failures++;
    $display("unexpected at %0t: run hung", $time);
    stop_test();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    {timer_a_count, timer_b_count, timer_select, route, lvl, flag_clear} = '0;
    {alt_pin_select_cfg, micro_mode, pins80_device, adc_enabled, unit_event_irq_enable, sw_write} = '0;
    void'($urandom(32'h87c0259a));
    tick(10);
    rst_b <= 1'b1;
    tick(2);
    for (u = 0; u < 3; u++) begin
      chk({unit_control[u], 8'h0, 3'h0, unit_event_flag[u]}, 16'h0, "reset state");
      chk(unit_data_pair[u] | 16'(unit_pin_out[u]), 16'h0, "reset data");
    end
    $display("reset test done");
    // Capture: every code, two rounds without clearing the flag
    for (u = 0; u < 3; u++) begin
      for (m = 4; m < 8; m++) begin
        shuffle();
        act = (m != 4);
        n = (m == 6) ? 4 : ((m == 7) ? 16 : 1);
        wr(CCU_SEL_CTRL, 8'h0);
        wr(CCU_SEL_CTRL, 8'(m));
        lvl[u] <= ~act;
        tick(4);
        clr();
        for (j = 0; j < 2; j++) begin
          timer_a_count <= 16'($urandom);
          timer_b_count <= 16'($urandom);
          tick(1);
          for (k = 0; k < n; k++) begin
            if (j == 0) chk(16'(unit_event_flag[u]), 16'h0, "early capture");
            lvl[u] <= act;
            tick(3);
            lvl[u] <= ~act;
            tick(3);
          end
          d = use_b(timer_select, u) ? timer_b_count : timer_a_count;
          chk(unit_data_pair[u], d, "captured time");
          chk(16'(unit_event_flag[u]), 16'h1, "capture flag");
          chk(16'(unit_event_irq[u]), 16'(unit_event_irq_enable[u]), "irq");
        end
        clr();
        chk(16'(unit_event_flag[u]), 16'h0, "flag clear");
      end
      wr(CCU_SEL_CTRL, 8'h0);
    end
    $display("capture test done");
    // Compare: every action code on every unit
    for (u = 0; u < 3; u++) begin
      foreach (cmodes[i]) begin
        m = cmodes[i];
        shuffle();
        b = use_b(timer_select, u);
        d = 16'($urandom) | 16'h0001;
        wr(CCU_SEL_CTRL, 8'h0);
        chk(16'(unit_pin_out[u]), 16'h0, "latch after clear");
        wr(CCU_SEL_LOW, d[7:0]);
        wr(CCU_SEL_HIGH, d[15:8]);
        chk(unit_data_pair[u], d, "data readback");
        timer_a_count <= b ? ~d : d - 16'h1;
        timer_b_count <= b ? d - 16'h1 : ~d;
        wr(CCU_SEL_CTRL, {4'h0, m[3:0]});
        chk(16'(unit_control[u]), 16'(m), "mode readback");
        clr();
        chk(16'(unit_pin_out[u]), 16'(m == 9), "latch init");
        if (b) timer_b_count <= d;
        else timer_a_count <= d;
        tick(2);
        chk(16'(unit_event_flag[u]), 16'h1, "match flag");
        lat = (m == 8) || (m == 2);
        chk(16'(unit_pin_out[u]), 16'(lat), "pin action");
        sp = (m == 11) && (u < 2);
        chk(16'({timer_a_reset, timer_b_reset, adc_start}),
            16'({sp && !b, sp && b, sp && u == 1 && adc_enabled}), "special event");
        o = (m == 2) || (m == 8) || (m == 9);
        chk(16'({unit_pin_own[u], portc_bit1_pin_own, porte_bit7_pin_own, portb_bit3_pin_own}),
            16'({o, u == 1 && o && route == 0, u == 1 && o && route == 1, u == 1 && o && route == 2}),
            "pin ownership");
        tick(1);
        chk(16'({timer_a_reset, timer_b_reset, adc_start}), 16'h0, "pulse end");
      end
      wr(CCU_SEL_CTRL, 8'h0);
    end
    $display("compare test done");
    stop_test();
  end
endmodule // test_capture_compare_units
